// ==== include/hbvm_pkg.sv ====
// Constants, carriers and state for the host bus and video memory port
// Summary of operation
// - High byte enable honoured only in wide mode
// - Port accesses always eight bit wide
// - Decode from upper address, bus, select
// - Wait-ready floats with no memory request
// - Wait-ready low until the column strobe cycle ends
// - Wait-ready high until both strobes end
// - Retrace interrupt set, held until bit cleared
// - Interrupt enabled: bit five clear, four set
// - Direction output low on host reads
// - Port response needs select, decode, awake
// - Clearing sequencer reset bits halts sequencer
// - Bus bits fifteen, fourteen latched at reset
// - Refresh blocks memory decode and access
// - DMA qualifier separates DMA from processor
// - Wide acknowledge needs wide mode, decode
// - Memory accessed only in A/B segments, any segment in extended decode
// - Write when cycle active, read high
// - Row then column strobe capture addresses
// - Write enable low, write at column fall
// - Small or large DRAM address multiplexing
// - Two plane buses, distinct in text with large DRAM
// - All timing from the master clock
package hbvm_pkg;
  localparam int unsigned MCLK_HZ      = 20_000_000;
  localparam int unsigned ADDR_W       = 8;
  localparam logic [7:0]  ADDR_CTRL    = 8'h00;
  localparam logic [7:0]  ADDR_REND    = 8'h04;
  localparam logic [7:0]  ADDR_SEQRST  = 8'h08;
  localparam logic [7:0]  ADDR_STATUS  = 8'h0c;
  // Control register fields
  localparam int unsigned CTL_WIDE     = 0;
  localparam int unsigned CTL_BIG      = 1;
  localparam int unsigned CTL_SLEEP    = 2;
  localparam int unsigned CTL_TEXT     = 3;
  localparam int unsigned CTL_DEC_LO   = 4;
  localparam int unsigned CTL_FONT_LO  = 6;
  localparam logic [7:0]  CTRL_RST     = 8'h00;
  // Retrace end register fields
  localparam int unsigned REND_CLR     = 4;
  localparam int unsigned REND_DIS     = 5;
  localparam logic [7:0]  REND_RST     = 8'h00;
  localparam logic [1:0]  SEQRST_RST   = 2'h3;
  // Decode selections
  localparam logic [1:0]  DEC_FULL     = 2'h0;
  localparam logic [1:0]  DEC_PART     = 2'h1;
  localparam logic [1:0]  DEC_EXT      = 2'h2;
  localparam logic [1:0]  SEG_AB_HI    = 2'h1;
  localparam int unsigned STRAP_LO     = 14;
  localparam logic [3:0]  RAS_ALL      = 4'hf;
  localparam logic [3:0]  RAS_EVEN     = 4'h5;
  localparam logic [3:0]  RAS_ODD      = 4'ha;
  localparam logic [3:0]  RAS_OFF      = 4'hf;

  typedef struct packed {
    logic        bhe_n;
    logic        aen;
    logic        bale;
    logic        ior_n;
    logic        iow_n;
    logic        memr_n;
    logic        memw_n;
    logic        refresh_n;
    logic        cs;
    logic [2:0]  upper;
    logic [15:0] ad;
  } hbvm_host_t;

  typedef struct packed {
    logic [3:0] ras_n;
    logic       cas_n;
    logic       we_n;
    logic [8:0] plane01;
    logic [8:0] plane23;
  } hbvm_dram_t;

  localparam hbvm_dram_t DRAM_IDLE = '{ras_n: RAS_OFF, cas_n: 1'b1, we_n: 1'b1, plane01: 9'h000, plane23: 9'h000};

  typedef enum logic [6:0] {
    S_IDLE = 7'h01,
    S_WAIT = 7'h02,
    S_RADR = 7'h04,
    S_ROW  = 7'h08,
    S_COLA = 7'h10,
    S_CAS  = 7'h20,
    S_DONE = 7'h40
  } hbvm_mem_state_t;

  typedef struct packed {
    hbvm_host_t      sync1;
    hbvm_host_t      sync2;
    logic [15:0]     lat_ad;
    logic [2:0]      lat_upper;
    logic            lat_cs;
    logic [1:0]      strap;
    hbvm_mem_state_t fsm;
    logic [3:0]      slot;
    logic            wide_xfer;
    logic [7:0]      ctrl;
    logic [7:0]      rend;
    logic [1:0]      seqrst;
    logic            irq;
    logic            vr_d;
    hbvm_dram_t      dram;
    logic            rdy;
    logic            rdy_oe;
    logic            dir;
    logic            ack_n;
    logic            cyc_n;
    logic            pready;
    logic            pslverr;
    logic [31:0]     prdata;
  } hbvm_state_t;
endpackage

// ==== rtl/hbvm_port.sv ====
// Host bus port with video memory strobe sequencing and APB registers
//
// Our own choices: the address map and the APB interface to the registers.
module hbvm_port
  import hbvm_pkg::*;
#(
  parameter logic [3:0] SLOT_LEN = 4'h4,
  parameter logic [9:0] IO_LO    = 10'h3c0,
  parameter logic [9:0] IO_HI    = 10'h3df,
  parameter logic [1:0] WIN_SA   = 2'h2
) (
  input  wire logic              mclk_in,
  input  wire logic              reset_in,
  input  wire hbvm_host_t        host_in,
  input  wire logic              vretrace_in,
  input  wire logic              psel_in,
  input  wire logic              penable_in,
  input  wire logic              pwrite_in,
  input  wire logic [ADDR_W-1:0] paddr_in,
  input  wire logic [31:0]       pwdata_in,
  output logic                   pready_out,
  output logic                   pslverr_out,
  output logic [31:0]            prdata_out,
  output logic                   host_wait_ready_out,
  output logic                   host_wait_ready_oe_out,
  output logic                   retrace_irq_out,
  output logic                   data_direction_ctl_out,
  output logic                   wide_access_ack_n_out,
  output logic                   cpu_cycle_active_n_out,
  output hbvm_dram_t             dram_out
);

  hbvm_state_t st_r;
  hbvm_state_t st_nxt;

  // Row or column half of an 18-bit plane address
  function automatic logic [8:0] hbvm_mux(input logic [17:0] a, input logic big, input logic col);
    logic [8:0] r;
    r = 9'h000;
    if (big) begin
      r = col ? a[8:0] : a[17:9];
    end else begin
      r = col ? {1'b0, a[7:0]} : {1'b0, a[15:8]};
    end
    return r;
  endfunction

  hbvm_host_t  h;
  logic        seg_hit;
  logic        mem_hit;
  logic        io_hit;
  logic        mem_rd;
  logic        mem_wr;
  logic        refresh_act;
  logic        grant;
  logic        irq_en;
  logic        vr_start;
  logic        clr_wr;
  logic        setup;
  logic        access;
  logic        wide_mode;
  logic [17:0] a01;
  logic [17:0] a23;

  always_comb begin
    st_nxt = st_r;
    // Two stages before anything reads a host pin
    st_nxt.sync1 = host_in;
    st_nxt.sync2 = st_r.sync1;
    h = st_r.sync2;
    wide_mode = st_r.ctrl[CTL_WIDE];
    mem_rd = ~h.memr_n;
    mem_wr = ~h.memw_n;
    refresh_act = ~h.refresh_n;
    st_nxt.vr_d = vretrace_in;

    // Address phase capture while the latch enable is high
    if (h.bale) begin
      st_nxt.lat_ad = h.ad;
      st_nxt.lat_upper = h.upper;
      st_nxt.lat_cs = h.cs;
    end
    seg_hit = st_r.lat_cs && (st_r.lat_upper[2:1] == SEG_AB_HI);
    unique case (st_r.ctrl[CTL_DEC_LO +: 2])
      DEC_FULL: mem_hit = seg_hit && (st_r.lat_ad[15:14] == WIN_SA);
      DEC_PART: mem_hit = seg_hit && (st_r.lat_ad[14] == WIN_SA[0]);
      DEC_EXT:  mem_hit = st_r.lat_cs;
      default:  mem_hit = 1'b0;
    endcase
    mem_hit = mem_hit && !refresh_act;
    // DMA cycles carry no valid port address
    io_hit = st_r.lat_cs && !st_r.ctrl[CTL_SLEEP] && !h.aen
           && (st_r.lat_ad[9:0] >= IO_LO) && (st_r.lat_ad[9:0] <= IO_HI);

    st_nxt.dir = !((~h.ior_n && io_hit) || (mem_rd && mem_hit));
    // Ports never get the wide acknowledge
    st_nxt.ack_n = !(wide_mode && mem_hit && !io_hit);

    // Slot timer is reloaded to SLOT_LEN during partial reset
    grant = 1'b0;
    if (st_r.seqrst != SEQRST_RST) begin
      st_nxt.slot = SLOT_LEN;
    end else if (st_r.slot == 4'h0) begin
      st_nxt.slot = SLOT_LEN;
      grant = 1'b1;
    end else begin
      st_nxt.slot = st_r.slot - 4'h1;
    end

    a01 = {1'b0, st_r.lat_upper[0], st_r.lat_ad};
    a23 = a01;
    if (st_r.ctrl[CTL_TEXT]) begin
      a23 = {st_r.ctrl[CTL_FONT_LO +: 2], a01[15:0]};
    end

    unique case (st_r.fsm)
      S_IDLE: begin
        st_nxt.rdy_oe = 1'b0;
        st_nxt.rdy = 1'b0;
        if ((mem_rd || mem_wr) && mem_hit) begin
          st_nxt.fsm = S_WAIT;
          st_nxt.rdy_oe = 1'b1;
          st_nxt.wide_xfer = wide_mode && !h.bhe_n;
        end
      end
      S_WAIT: begin
        if (!(mem_rd || mem_wr)) begin
          st_nxt.fsm = S_IDLE;
          st_nxt.rdy_oe = 1'b0;
        end else if (grant) begin
          st_nxt.fsm = S_RADR;
          st_nxt.cyc_n = 1'b0;
          st_nxt.dram.plane01 = hbvm_mux(a01, st_r.ctrl[CTL_BIG], 1'b0);
          st_nxt.dram.plane23 = hbvm_mux(a23, st_r.ctrl[CTL_BIG], 1'b0);
        end
      end
      S_RADR: begin
        st_nxt.fsm = S_ROW;
        // Byte transfers open only the even or odd bank
        if (st_r.wide_xfer) begin
          st_nxt.dram.ras_n = ~RAS_ALL;
        end else begin
          st_nxt.dram.ras_n = st_r.lat_ad[0] ? ~RAS_ODD : ~RAS_EVEN;
        end
      end
      S_ROW: begin
        st_nxt.fsm = S_COLA;
        st_nxt.dram.plane01 = hbvm_mux(a01, st_r.ctrl[CTL_BIG], 1'b1);
        st_nxt.dram.plane23 = hbvm_mux(a23, st_r.ctrl[CTL_BIG], 1'b1);
        st_nxt.dram.we_n = !(!st_r.cyc_n && h.memr_n);
      end
      S_COLA: begin
        st_nxt.fsm = S_CAS;
        st_nxt.dram.cas_n = 1'b0;
      end
      S_CAS: begin
        st_nxt.fsm = S_DONE;
        st_nxt.dram = DRAM_IDLE;
        st_nxt.cyc_n = 1'b1;
        st_nxt.rdy = 1'b1;
      end
      S_DONE: begin
        if (h.memr_n && h.memw_n) begin
          st_nxt.fsm = S_IDLE;
          st_nxt.rdy = 1'b0;
          st_nxt.rdy_oe = 1'b0;
        end
      end
    endcase

    // APB slave, no wait state, registered answer
    setup = psel_in && !penable_in;
    access = psel_in && penable_in && st_r.pready;
    st_nxt.pready = setup;
    if (setup) begin
      st_nxt.pslverr = 1'b0;
      unique case (paddr_in)
        ADDR_CTRL:   st_nxt.prdata = {24'h000000, st_r.ctrl};
        ADDR_REND:   st_nxt.prdata = {24'h000000, st_r.rend};
        ADDR_SEQRST: st_nxt.prdata = {30'h00000000, st_r.seqrst};
        ADDR_STATUS: st_nxt.prdata = {22'h000000, st_r.fsm, st_r.irq, st_r.strap};
        default: begin
          st_nxt.prdata = 32'h00000000;
          st_nxt.pslverr = 1'b1;
        end
      endcase
    end else if (access) begin
      st_nxt.pslverr = 1'b0;
      st_nxt.prdata = 32'h00000000;
    end
    clr_wr = 1'b0;
    if (access && pwrite_in) begin
      unique case (paddr_in)
        ADDR_CTRL:   st_nxt.ctrl = pwdata_in[7:0];
        ADDR_REND: begin
          st_nxt.rend = pwdata_in[7:0];
          clr_wr = !pwdata_in[REND_CLR];
        end
        ADDR_SEQRST: st_nxt.seqrst = pwdata_in[1:0];
        default:     st_nxt.seqrst = st_r.seqrst;
      endcase
    end

    // Retrace interrupt; an arriving edge beats the clearing write
    irq_en = st_r.rend[REND_CLR] && !st_r.rend[REND_DIS];
    vr_start = vretrace_in && !st_r.vr_d;
    if (vr_start && irq_en) begin
      st_nxt.irq = 1'b1;
    end else if (clr_wr) begin
      st_nxt.irq = 1'b0;
    end

    // Synchroniser keeps running so the straps see settled pins
    if (reset_in) begin
      st_nxt.strap = st_r.sync2.ad[STRAP_LO +: 2];
      st_nxt.lat_ad = 16'h0000;
      st_nxt.lat_upper = 3'h0;
      st_nxt.lat_cs = 1'b0;
      st_nxt.fsm = S_IDLE;
      st_nxt.slot = SLOT_LEN;
      st_nxt.wide_xfer = 1'b0;
      st_nxt.ctrl = CTRL_RST;
      st_nxt.rend = REND_RST;
      st_nxt.seqrst = SEQRST_RST;
      st_nxt.irq = 1'b0;
      st_nxt.vr_d = 1'b0;
      st_nxt.dram = DRAM_IDLE;
      st_nxt.rdy = 1'b0;
      st_nxt.rdy_oe = 1'b0;
      st_nxt.dir = 1'b1;
      st_nxt.ack_n = 1'b1;
      st_nxt.cyc_n = 1'b1;
      st_nxt.pready = 1'b0;
      st_nxt.pslverr = 1'b0;
      st_nxt.prdata = 32'h00000000;
    end
  end

  always_ff @(posedge mclk_in) begin
    st_r <= st_nxt;
  end

  assign pready_out             = st_r.pready;
  assign pslverr_out            = st_r.pslverr;
  assign prdata_out             = st_r.prdata;
  assign host_wait_ready_out    = st_r.rdy;
  assign host_wait_ready_oe_out = st_r.rdy_oe;
  assign retrace_irq_out        = st_r.irq;
  assign data_direction_ctl_out = st_r.dir;
  assign wide_access_ack_n_out  = st_r.ack_n;
  assign cpu_cycle_active_n_out = st_r.cyc_n;
  assign dram_out               = st_r.dram;

  default clocking cb @(posedge mclk_in);
  endclocking
  default disable iff (reset_in);

  sequence s_grant;
    st_r.fsm == S_WAIT ##1 st_r.fsm == S_RADR;
  endsequence
  sequence s_strobe;
    st_r.fsm == S_ROW ##1 st_r.fsm == S_COLA ##1 st_r.fsm == S_CAS ##1 st_r.fsm == S_DONE;
  endsequence

  a_rdy_float_idle: assert property (st_r.fsm == S_IDLE |-> !host_wait_ready_oe_out)
    else $error("wait-ready driven with no request");
  a_rdy_low_wait: assert property (st_r.fsm == S_WAIT |-> host_wait_ready_oe_out && !host_wait_ready_out)
    else $error("wait-ready not low while waiting");
  a_slot_hold: assert property (st_r.fsm == S_WAIT && st_r.seqrst != SEQRST_RST
                                 && (mem_rd || mem_wr) |=> st_r.fsm == S_WAIT)
    else $error("sequencer granted during partial reset");
  a_cycle_order: assert property (s_grant |=> s_strobe)
    else $error("strobe sequence out of order");
  a_rdy_high_end: assert property ($fell(st_r.fsm == S_DONE) |-> $past(h.memr_n && h.memw_n)
                                   && !host_wait_ready_oe_out && $past(host_wait_ready_out))
    else $error("wait-ready released while strobe active");
  a_cas_after_ras: assert property ($fell(dram_out.cas_n) |-> dram_out.ras_n != RAS_OFF
                                    && $past(dram_out.ras_n, 2) != RAS_OFF)
    else $error("column strobe without open row");
  a_we_with_cas: assert property ($fell(dram_out.we_n) |-> ##1 !dram_out.cas_n)
    else $error("write enable not followed by column strobe");
  a_write_cause: assert property ($fell(dram_out.we_n) |-> $past(!cpu_cycle_active_n_out && h.memr_n))
    else $error("write without active cycle and idle read");
  a_irq_set: assert property (vr_start && irq_en |=> retrace_irq_out)
    else $error("retrace interrupt missed");
  a_irq_gate: assert property ($rose(retrace_irq_out) |-> $past(irq_en && vr_start))
    else $error("retrace interrupt while disabled");
  a_ack_wide: assert property (!wide_access_ack_n_out |-> $past(wide_mode && !io_hit))
    else $error("wide acknowledge outside wide mode");
  a_dir_read: assert property ((~h.ior_n && io_hit) |=> !data_direction_ctl_out)
    else $error("direction not low on port read");
  a_refresh_block: assert property (st_r.fsm == S_IDLE && refresh_act |=> st_r.fsm == S_IDLE)
    else $error("access started during refresh");
endmodule

// ==== verif/hbvm_host_model.sv ====
// Host expansion bus model driving the raw host pins of the port
module hbvm_host_model
  import hbvm_pkg::*;
(
  input  wire logic mclk_in,
  input  wire logic rdy_in,
  input  wire logic oe_in,
  output hbvm_host_t host_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // Strap pattern stands on the bus while reset is held
  initial host_out = '{bhe_n: 1'b1, aen: 1'b0, bale: 1'b0, ior_n: 1'b1, iow_n: 1'b1, memr_n: 1'b1,
                       memw_n: 1'b1, refresh_n: 1'b1, cs: 1'b0, upper: 3'h0, ad: 16'h8000};
  // One bus cycle; wt bounds the stall so a dead ready cannot hang the host
  task automatic cycle(input logic io, rd, input logic [2:0] up, input logic [15:0] a,
                       input logic bhe_n, rf_n, input int wt, output logic got);
    int n;
    got = 1'b0;
    @(posedge mclk_in);
    host_out.aen       <= 1'b0;
    host_out.bale      <= 1'b1;
    host_out.cs        <= 1'b1;
    host_out.upper     <= up;
    host_out.ad        <= a;
    host_out.bhe_n     <= bhe_n;
    host_out.refresh_n <= rf_n;
    repeat (3) @(posedge mclk_in);
    host_out.bale <= 1'b0;
    host_out.ad   <= ~a;
    {host_out.memr_n, host_out.memw_n, host_out.ior_n, host_out.iow_n} <= io ? {2'b11, ~rd, rd} : {~rd, rd, 2'b11};
    for (n = 0; n < wt && !got; n++) begin
      @(posedge mclk_in);
      got = (rdy_in === 1'b1 && oe_in === 1'b1);
    end
    {host_out.memr_n, host_out.memw_n, host_out.ior_n, host_out.iow_n} <= 4'hf;
    host_out.bhe_n     <= 1'b1;
    host_out.refresh_n <= 1'b1;
    // Released bus goes back to the address rather than holding data
    host_out.ad        <= a;
    repeat (4) @(posedge mclk_in);
  endtask
endmodule

// ==== verif/hbvm_port_tb_top.sv ====
// Testbench for the host bus and video memory port
module hbvm_port_tb_top;
  import hbvm_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic        mclk    = 1'b0;
  logic        reset   = 1'b1;
  logic        vr      = 1'b0;
  logic        psel    = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite  = 1'b0;
  logic [7:0]  paddr   = 8'h00;
  logic [31:0] pwdata  = 32'h0;
  logic        pready, pslverr, rdy, oe, irq, dir, ack_n, cyc_n;
  logic [31:0] prdata, q;
  logic        e;
  logic [5:0]  seen;
  logic [3:0]  ras_and;
  hbvm_host_t  host;
  hbvm_dram_t  dram;
  int          error_cnt = 0;
  int          samples_checked = 0;

  always #25 mclk = ~mclk;

  hbvm_port hbvm_port_inst (.mclk_in(mclk), .reset_in(reset), .host_in(host), .vretrace_in(vr),
    .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
    .pready_out(pready), .pslverr_out(pslverr), .prdata_out(prdata), .host_wait_ready_out(rdy),
    .host_wait_ready_oe_out(oe), .retrace_irq_out(irq), .data_direction_ctl_out(dir),
    .wide_access_ack_n_out(ack_n), .cpu_cycle_active_n_out(cyc_n), .dram_out(dram));
  hbvm_host_model hbvm_host_model_inst (.mclk_in(mclk), .rdy_in(rdy), .oe_in(oe), .host_out(host));

  // Sticky record of pin events within one host cycle
  // Sampled mid-cycle so registered pins are settled
  always @(negedge mclk) begin
    seen = seen | {~ack_n, ~dir, ~cyc_n, ~dram.we_n, oe & rdy, oe & ~rdy};
    ras_and = ras_and & dram.ras_n;
  end

  task automatic end_sim;
    $display("checks %0d errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(negedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) error_cnt++;
    q = prdata;
    e = pslverr;
    @(posedge mclk);
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
  endtask

  task automatic mchk(input logic io, wr, input logic [2:0] up, input logic [15:0] a, input logic bhe, rf,
                      input int wt, input logic eg, input logic [5:0] es, input logic [3:0] er);
    logic g;
    seen = '0;
    ras_and = 4'hf;
    hbvm_host_model_inst.cycle(io, wr, up, a, bhe, rf, wt, g);
    chk("ready seen", {31'h0, g}, {31'h0, eg});
    chk("pin events", {26'h0, seen}, {26'h0, es});
    chk("row strobes", {28'h0, ras_and}, {28'h0, er});
    chk("ready float", {31'h0, oe}, 32'h0);
  endtask

  task automatic irq_chk(input logic pulse, input logic x);
    vr <= pulse;
    @(posedge mclk);
    vr <= 1'b0;
    repeat (3) @(posedge mclk);
    chk("retrace irq", {31'h0, irq}, {31'h0, x});
  endtask

  initial begin
    seen = '0;
    ras_and = 4'hf;
    repeat (4) @(posedge mclk);
    reset <= 1'b0;
    @(posedge mclk);
    chk("idle pins", {26'h0, oe, irq, dir, ack_n, cyc_n, dram.ras_n == 4'hf}, 32'h0f);
    apb(1'b0, ADDR_CTRL, 32'h0);
    chk("ctrl reset", q, {24'h0, CTRL_RST});
    apb(1'b0, ADDR_SEQRST, 32'h0);
    chk("seq reset", q, {30'h0, SEQRST_RST});
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk("strap", {30'h0, q[1:0]}, 32'h2);
    apb(1'b0, 8'h10, 32'h0);
    chk("unmapped", {q[30:0], e}, 32'h1);
    mchk(1'b0, 1'b1, 3'h2, 16'h8000, 1'b1, 1'b1, 30, 1'b1, 6'h1b, 4'ha);
    mchk(1'b0, 1'b0, 3'h2, 16'h8001, 1'b1, 1'b1, 30, 1'b1, 6'h0f, 4'h5);
    mchk(1'b0, 1'b1, 3'h0, 16'h8000, 1'b1, 1'b1, 12, 1'b0, 6'h00, 4'hf);
    mchk(1'b0, 1'b1, 3'h2, 16'h8000, 1'b1, 1'b0, 12, 1'b0, 6'h00, 4'hf);
    mchk(1'b0, 1'b1, 3'h2, 16'h0000, 1'b1, 1'b1, 12, 1'b0, 6'h00, 4'hf);
    mchk(1'b1, 1'b1, 3'h0, 16'h03c4, 1'b1, 1'b1, 6, 1'b0, 6'h10, 4'hf);
    apb(1'b1, ADDR_CTRL, 32'h10);
    mchk(1'b0, 1'b1, 3'h2, 16'h0000, 1'b1, 1'b1, 30, 1'b1, 6'h1b, 4'ha);
    apb(1'b1, ADDR_CTRL, 32'h01);
    mchk(1'b0, 1'b1, 3'h2, 16'h8000, 1'b0, 1'b1, 30, 1'b1, 6'h3b, 4'h0);
    mchk(1'b0, 1'b1, 3'h2, 16'h8000, 1'b1, 1'b1, 30, 1'b1, 6'h3b, 4'ha);
    mchk(1'b1, 1'b1, 3'h2, 16'h83c4, 1'b0, 1'b1, 6, 1'b0, 6'h30, 4'hf);
    chk("port ack", {31'h0, ack_n}, 32'h1);
    apb(1'b1, ADDR_CTRL, 32'h04);
    mchk(1'b1, 1'b1, 3'h0, 16'h03c4, 1'b1, 1'b1, 6, 1'b0, 6'h00, 4'hf);
    apb(1'b1, ADDR_CTRL, 32'h00);
    // Halted sequencer never grants, so the host stays stalled
    apb(1'b1, ADDR_SEQRST, 32'h0);
    mchk(1'b0, 1'b1, 3'h2, 16'h8000, 1'b1, 1'b1, 40, 1'b0, 6'h11, 4'hf);
    apb(1'b1, ADDR_SEQRST, 32'h3);
    apb(1'b1, ADDR_REND, 32'h10);
    irq_chk(1'b1, 1'b1);
    apb(1'b1, ADDR_REND, 32'h00);
    irq_chk(1'b0, 1'b0);
    irq_chk(1'b1, 1'b0);
    apb(1'b1, ADDR_REND, 32'h10);
    irq_chk(1'b1, 1'b1);
    apb(1'b1, ADDR_REND, 32'h00);
    apb(1'b1, ADDR_REND, 32'h30);
    irq_chk(1'b1, 1'b0);
    end_sim;
  end

  // Whole run needs a few hundred cycles
  initial begin
    repeat (20000) @(posedge mclk);
    error_cnt++;
    end_sim;
  end
endmodule
